// File: ipb_pkg.sv
// package: register map, field layout and carrier types of the interrupt priority bank
// Function
// - field code 111 gives the source level 7, the highest level
// - code 001 is level 1, lowest active; codes between map to matching levels
// - code 000 disables the source; it never raises a request
// - bits without a priority field read as zero and ignore writes
// - at reset each field loads msb set, two lower bits cleared
// - every implemented field is readable and writable by software
// - dma channel 4 at bits 10:8, parallel port at bits 6:4
// - i2c2 master event at bits 10:8, i2c2 slave event at bits 6:4
// - external interrupt 4 at bits 10:8, external interrupt 3 at bits 6:4
// - clock calendar at bits 10:8, dma channel 5 at bits 6:4
// - checksum error 14:12, uart2 error 10:8, uart1 error 6:4
// - low voltage detect at bits 2:0, bits 15:3 unimplemented
// - charge time unit at bits 6:4, other bits unimplemented
// - uart3 transmit 14:12, uart3 receive 10:8, uart3 error 6:4
// - after any reset every source sits at priority level 4
package ipb_pkg;

    localparam int IPB_ADDR_W = 8;
    localparam int IPB_DATA_W = 32;
    localparam int IPB_REG_W = 16;
    localparam int IPB_FIELD_W = 3;
    localparam int IPB_NUM_REGS = 8;
    localparam int IPB_NUM_SRC = 16;

    // byte offsets of the priority registers
    localparam logic [7:0] IPB_OFS_DMA4_PARPORT = 8'h00;
    localparam logic [7:0] IPB_OFS_I2C2_EVENTS = 8'h04;
    localparam logic [7:0] IPB_OFS_EXT_INT_3_4 = 8'h08;
    localparam logic [7:0] IPB_OFS_CLOCK_CAL_DMA5 = 8'h0C;
    localparam logic [7:0] IPB_OFS_CRC_UART_ERRORS = 8'h10;
    localparam logic [7:0] IPB_OFS_LOW_VOLTAGE = 8'h14;
    localparam logic [7:0] IPB_OFS_CHARGE_TIME_UNIT = 8'h18;
    localparam logic [7:0] IPB_OFS_UART3_ALL = 8'h1C;

    // field positions (lsb of each 3-bit field)
    localparam int IPB_POS_TOP = 12;
    localparam int IPB_POS_HIGH = 8;
    localparam int IPB_POS_MID = 4;
    localparam int IPB_POS_LOW = 0;

    // level 4 after reset
    localparam logic [2:0] IPB_PRIO_RESET = 3'h4;
    localparam logic [2:0] IPB_PRIO_OFF = 3'h0;

    // source order in the request vectors
    localparam int IPB_SRC_DMA4 = 0;
    localparam int IPB_SRC_PARPORT = 1;
    localparam int IPB_SRC_I2C2_MST = 2;
    localparam int IPB_SRC_I2C2_SLV = 3;
    localparam int IPB_SRC_EXT4 = 4;
    localparam int IPB_SRC_EXT3 = 5;
    localparam int IPB_SRC_CLOCK_CAL = 6;
    localparam int IPB_SRC_DMA5 = 7;
    localparam int IPB_SRC_CHECKSUM = 8;
    localparam int IPB_SRC_UART2_ERR = 9;
    localparam int IPB_SRC_UART1_ERR = 10;
    localparam int IPB_SRC_LOW_VOLT = 11;
    localparam int IPB_SRC_CHARGE_TIME = 12;
    localparam int IPB_SRC_UART3_TX = 13;
    localparam int IPB_SRC_UART3_RX = 14;
    localparam int IPB_SRC_UART3_ERR = 15;

    typedef struct packed {
        logic [2:0] dma_ch4_priority;
        logic [2:0] parallel_port_priority;
        logic [2:0] i2c2_master_priority;
        logic [2:0] i2c2_slave_priority;
        logic [2:0] ext_irq4_priority;
        logic [2:0] ext_irq3_priority;
        logic [2:0] clock_calendar_priority;
        logic [2:0] dma_ch5_priority;
        logic [2:0] checksum_error_priority;
        logic [2:0] uart2_error_priority;
        logic [2:0] uart1_error_priority;
        logic [2:0] low_voltage_priority;
        logic [2:0] charge_time_priority;
        logic [2:0] uart3_transmit_priority;
        logic [2:0] uart3_receive_priority;
        logic [2:0] uart3_error_priority;
    } ipb_prio_bank_type;

endpackage

// File: ipb_priority_bank.sv
// module: apb slave holding the interrupt priority fields and gating source requests
`timescale 1ns/1ps
module ipb_priority_bank
    import ipb_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [IPB_ADDR_W-1:0] paddr,
    input wire logic [IPB_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [IPB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // toward arbitration
    output ipb_prio_bank_type prio_levels,
    // peripheral requests in, gated requests out
    input wire logic [IPB_NUM_SRC-1:0] src_req,
    output logic [IPB_NUM_SRC-1:0] req_active
);

    logic [2:0] dma_ch4_priority_ff;
    logic [2:0] parallel_port_priority_ff;
    logic [2:0] i2c2_master_priority_ff;
    logic [2:0] i2c2_slave_priority_ff;
    logic [2:0] ext_irq4_priority_ff;
    logic [2:0] ext_irq3_priority_ff;
    logic [2:0] clock_calendar_priority_ff;
    logic [2:0] dma_ch5_priority_ff;
    logic [2:0] checksum_error_priority_ff;
    logic [2:0] uart2_error_priority_ff;
    logic [2:0] uart1_error_priority_ff;
    logic [2:0] low_voltage_priority_ff;
    logic [2:0] charge_time_priority_ff;
    logic [2:0] uart3_transmit_priority_ff;
    logic [2:0] uart3_receive_priority_ff;
    logic [2:0] uart3_error_priority_ff;

    logic [IPB_DATA_W-1:0] prdata_ff;
    logic [IPB_DATA_W-1:0] nxt_prdata;
    logic pslverr_ff;
    logic [IPB_NUM_SRC-1:0] req_active_ff;
    logic [IPB_NUM_SRC-1:0] nxt_req_active;
    logic [IPB_NUM_REGS-1:0] reg_hit;
    logic [IPB_REG_W-1:0] rd_word;
    logic setup_phase;
    logic wr_access;
    logic wr_lo;
    logic wr_hi;
    logic [2:0] prio_vec [IPB_NUM_SRC];

    assign setup_phase = psel && !penable;
    // zero wait states: read data was captured in the setup cycle
    assign pready = psel && penable;
    assign wr_access = psel && penable && pwrite;
    assign wr_lo = wr_access && pstrb[0];
    assign wr_hi = wr_access && pstrb[1];
    assign prdata = prdata_ff;
    // error only shows during the access phase, where the master samples it
    assign pslverr = pslverr_ff && psel && penable;
    assign req_active = req_active_ff;

    // address decode; misaligned addresses fall through as unmapped
    always_comb
    begin
        reg_hit = '0;
        if (paddr == IPB_OFS_DMA4_PARPORT)
            reg_hit[0] = 1'b1;
        else if (paddr == IPB_OFS_I2C2_EVENTS)
            reg_hit[1] = 1'b1;
        else if (paddr == IPB_OFS_EXT_INT_3_4)
            reg_hit[2] = 1'b1;
        else if (paddr == IPB_OFS_CLOCK_CAL_DMA5)
            reg_hit[3] = 1'b1;
        else if (paddr == IPB_OFS_CRC_UART_ERRORS)
            reg_hit[4] = 1'b1;
        else if (paddr == IPB_OFS_LOW_VOLTAGE)
            reg_hit[5] = 1'b1;
        else if (paddr == IPB_OFS_CHARGE_TIME_UNIT)
            reg_hit[6] = 1'b1;
        else if (paddr == IPB_OFS_UART3_ALL)
            reg_hit[7] = 1'b1;
    end

    // read image: unused positions stay zero
    always_comb
    begin
        rd_word = '0;
        if (reg_hit[0])
        begin
            rd_word[IPB_POS_HIGH +: IPB_FIELD_W] = dma_ch4_priority_ff;
            rd_word[IPB_POS_MID +: IPB_FIELD_W] = parallel_port_priority_ff;
        end
        else if (reg_hit[1])
        begin
            rd_word[IPB_POS_HIGH +: IPB_FIELD_W] = i2c2_master_priority_ff;
            rd_word[IPB_POS_MID +: IPB_FIELD_W] = i2c2_slave_priority_ff;
        end
        else if (reg_hit[2])
        begin
            rd_word[IPB_POS_HIGH +: IPB_FIELD_W] = ext_irq4_priority_ff;
            rd_word[IPB_POS_MID +: IPB_FIELD_W] = ext_irq3_priority_ff;
        end
        else if (reg_hit[3])
        begin
            rd_word[IPB_POS_HIGH +: IPB_FIELD_W] = clock_calendar_priority_ff;
            rd_word[IPB_POS_MID +: IPB_FIELD_W] = dma_ch5_priority_ff;
        end
        else if (reg_hit[4])
        begin
            rd_word[IPB_POS_TOP +: IPB_FIELD_W] = checksum_error_priority_ff;
            rd_word[IPB_POS_HIGH +: IPB_FIELD_W] = uart2_error_priority_ff;
            rd_word[IPB_POS_MID +: IPB_FIELD_W] = uart1_error_priority_ff;
        end
        else if (reg_hit[5])
        begin
            rd_word[IPB_POS_LOW +: IPB_FIELD_W] = low_voltage_priority_ff;
        end
        else if (reg_hit[6])
        begin
            rd_word[IPB_POS_MID +: IPB_FIELD_W] = charge_time_priority_ff;
        end
        else if (reg_hit[7])
        begin
            rd_word[IPB_POS_TOP +: IPB_FIELD_W] = uart3_transmit_priority_ff;
            rd_word[IPB_POS_HIGH +: IPB_FIELD_W] = uart3_receive_priority_ff;
            rd_word[IPB_POS_MID +: IPB_FIELD_W] = uart3_error_priority_ff;
        end
    end

    always_comb
    begin
        // a write loads zero so stale read data never lingers on the bus
        nxt_prdata = '0;
        if (!pwrite)
            nxt_prdata[IPB_REG_W-1:0] = rd_word;
    end

    // read data and error captured at setup, held through the access phase
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata_ff <= nxt_prdata;
            pslverr_ff <= ~|reg_hit;
        end
    end

    // fields above bit 7 follow byte lane 1, the others lane 0
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            dma_ch4_priority_ff <= IPB_PRIO_RESET;
            parallel_port_priority_ff <= IPB_PRIO_RESET;
        end
        else if (reg_hit[0])
        begin
            if (wr_hi)
            begin
                dma_ch4_priority_ff <= pwdata[IPB_POS_HIGH +: IPB_FIELD_W];
            end
            if (wr_lo)
            begin
                parallel_port_priority_ff <= pwdata[IPB_POS_MID +: IPB_FIELD_W];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            i2c2_master_priority_ff <= IPB_PRIO_RESET;
            i2c2_slave_priority_ff <= IPB_PRIO_RESET;
        end
        else if (reg_hit[1])
        begin
            if (wr_hi)
            begin
                i2c2_master_priority_ff <= pwdata[IPB_POS_HIGH +: IPB_FIELD_W];
            end
            if (wr_lo)
            begin
                i2c2_slave_priority_ff <= pwdata[IPB_POS_MID +: IPB_FIELD_W];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ext_irq4_priority_ff <= IPB_PRIO_RESET;
            ext_irq3_priority_ff <= IPB_PRIO_RESET;
        end
        else if (reg_hit[2])
        begin
            if (wr_hi)
            begin
                ext_irq4_priority_ff <= pwdata[IPB_POS_HIGH +: IPB_FIELD_W];
            end
            if (wr_lo)
            begin
                ext_irq3_priority_ff <= pwdata[IPB_POS_MID +: IPB_FIELD_W];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            clock_calendar_priority_ff <= IPB_PRIO_RESET;
            dma_ch5_priority_ff <= IPB_PRIO_RESET;
        end
        else if (reg_hit[3])
        begin
            if (wr_hi)
            begin
                clock_calendar_priority_ff <= pwdata[IPB_POS_HIGH +: IPB_FIELD_W];
            end
            if (wr_lo)
            begin
                dma_ch5_priority_ff <= pwdata[IPB_POS_MID +: IPB_FIELD_W];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            checksum_error_priority_ff <= IPB_PRIO_RESET;
            uart2_error_priority_ff <= IPB_PRIO_RESET;
            uart1_error_priority_ff <= IPB_PRIO_RESET;
        end
        else if (reg_hit[4])
        begin
            if (wr_hi)
            begin
                checksum_error_priority_ff <= pwdata[IPB_POS_TOP +: IPB_FIELD_W];
                uart2_error_priority_ff <= pwdata[IPB_POS_HIGH +: IPB_FIELD_W];
            end
            if (wr_lo)
            begin
                uart1_error_priority_ff <= pwdata[IPB_POS_MID +: IPB_FIELD_W];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        // the only field of this register sits in byte lane 0
        if (rst)
        begin
            low_voltage_priority_ff <= IPB_PRIO_RESET;
        end
        else if (reg_hit[5] && wr_lo)
        begin
            low_voltage_priority_ff <= pwdata[IPB_POS_LOW +: IPB_FIELD_W];
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        // bits 6:4 also ride on byte lane 0, so lane 1 is ignored here
        if (rst)
        begin
            charge_time_priority_ff <= IPB_PRIO_RESET;
        end
        else if (reg_hit[6] && wr_lo)
        begin
            charge_time_priority_ff <= pwdata[IPB_POS_MID +: IPB_FIELD_W];
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            uart3_transmit_priority_ff <= IPB_PRIO_RESET;
            uart3_receive_priority_ff <= IPB_PRIO_RESET;
            uart3_error_priority_ff <= IPB_PRIO_RESET;
        end
        else if (reg_hit[7])
        begin
            if (wr_hi)
            begin
                uart3_transmit_priority_ff <= pwdata[IPB_POS_TOP +: IPB_FIELD_W];
                uart3_receive_priority_ff <= pwdata[IPB_POS_HIGH +: IPB_FIELD_W];
            end
            if (wr_lo)
            begin
                uart3_error_priority_ff <= pwdata[IPB_POS_MID +: IPB_FIELD_W];
            end
        end
    end

    // field codes pass straight through as levels 0..7
    always_comb
    begin
        prio_levels.dma_ch4_priority = dma_ch4_priority_ff;
        prio_levels.parallel_port_priority = parallel_port_priority_ff;
        prio_levels.i2c2_master_priority = i2c2_master_priority_ff;
        prio_levels.i2c2_slave_priority = i2c2_slave_priority_ff;
        prio_levels.ext_irq4_priority = ext_irq4_priority_ff;
        prio_levels.ext_irq3_priority = ext_irq3_priority_ff;
        prio_levels.clock_calendar_priority = clock_calendar_priority_ff;
        prio_levels.dma_ch5_priority = dma_ch5_priority_ff;
        prio_levels.checksum_error_priority = checksum_error_priority_ff;
        prio_levels.uart2_error_priority = uart2_error_priority_ff;
        prio_levels.uart1_error_priority = uart1_error_priority_ff;
        prio_levels.low_voltage_priority = low_voltage_priority_ff;
        prio_levels.charge_time_priority = charge_time_priority_ff;
        prio_levels.uart3_transmit_priority = uart3_transmit_priority_ff;
        prio_levels.uart3_receive_priority = uart3_receive_priority_ff;
        prio_levels.uart3_error_priority = uart3_error_priority_ff;
    end

    // 111 is level 7 and 001 level 1, unsigned order, so no recoding is needed
    always_comb
    begin
        prio_vec[IPB_SRC_DMA4] = dma_ch4_priority_ff;
        prio_vec[IPB_SRC_PARPORT] = parallel_port_priority_ff;
        prio_vec[IPB_SRC_I2C2_MST] = i2c2_master_priority_ff;
        prio_vec[IPB_SRC_I2C2_SLV] = i2c2_slave_priority_ff;
        prio_vec[IPB_SRC_EXT4] = ext_irq4_priority_ff;
        prio_vec[IPB_SRC_EXT3] = ext_irq3_priority_ff;
        prio_vec[IPB_SRC_CLOCK_CAL] = clock_calendar_priority_ff;
        prio_vec[IPB_SRC_DMA5] = dma_ch5_priority_ff;
        prio_vec[IPB_SRC_CHECKSUM] = checksum_error_priority_ff;
        prio_vec[IPB_SRC_UART2_ERR] = uart2_error_priority_ff;
        prio_vec[IPB_SRC_UART1_ERR] = uart1_error_priority_ff;
        prio_vec[IPB_SRC_LOW_VOLT] = low_voltage_priority_ff;
        prio_vec[IPB_SRC_CHARGE_TIME] = charge_time_priority_ff;
        prio_vec[IPB_SRC_UART3_TX] = uart3_transmit_priority_ff;
        prio_vec[IPB_SRC_UART3_RX] = uart3_receive_priority_ff;
        prio_vec[IPB_SRC_UART3_ERR] = uart3_error_priority_ff;
    end

    // a disabled source is masked here so arbitration never sees it
    always_comb
    begin
        nxt_req_active = '0;
        for (int i = 0; i < IPB_NUM_SRC; i++)
        begin
            nxt_req_active[i] = src_req[i] && (prio_vec[i] != IPB_PRIO_OFF);
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        // registered so arbitration never sees a glitch from the compare
        if (rst)
        begin
            req_active_ff <= '0;
        end
        else
        begin
            req_active_ff <= nxt_req_active;
        end
    end

endmodule

// File: ipb_priority_bank_properties.sv
// checker: port-level timing and field properties of the priority bank
`timescale 1ns/1ps
module ipb_priority_bank_properties
    import ipb_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [IPB_ADDR_W-1:0] paddr,
    input wire logic [IPB_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [IPB_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // arbitration side
    input wire ipb_prio_bank_type prio_levels,
    input wire logic [IPB_NUM_SRC-1:0] src_req,
    input wire logic [IPB_NUM_SRC-1:0] req_active
);
    logic acc;
    logic mapped;
    logic [15:0] nz;
    logic [2:0] wd_low;
    logic [2:0] wd_high;
    logic [2:0] wd_top;
    assign acc = psel && penable;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr < 8'h20);
    assign wd_low = pwdata[2:0];
    assign wd_high = pwdata[10:8];
    assign wd_top = pwdata[14:12];
    always_comb
    begin
        for (int i = 0; i < 16; i++) nz[i] = prio_levels[47-3*i -: 3] != 3'h0;
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    a_ready_zero_wait: assert property (pready == acc)
        else $error("pready does not follow the access phase");
    // no check across the release edge: the flop was still held there
    a_req_gated_level: assert property (!rst |=>
        req_active == ($past(src_req) & $past(nz)))
        else $error("gated request does not match source and field");
    // one edge later, so the very first edge with unset flops is not judged
    a_reset_all_four: assert property (disable iff (1'b0) rst |=>
        prio_levels == {16{3'h4}} && req_active == 16'h0)
        else $error("reset state is not level four everywhere");
    a_low_volt_write: assert property (acc && pwrite && paddr == 8'h14 && pstrb[0]
        |=> prio_levels.low_voltage_priority == $past(wd_low))
        else $error("low voltage field missed a write");
    a_uart3_tx_write: assert property (acc && pwrite && paddr == 8'h1C && pstrb[1]
        |=> prio_levels.uart3_transmit_priority == $past(wd_top))
        else $error("uart3 transmit field missed a write");
    a_dma4_write: assert property (acc && pwrite && paddr == 8'h00 && pstrb[1]
        |=> prio_levels.dma_ch4_priority == $past(wd_high))
        else $error("dma channel 4 field missed a write");
    a_levels_hold: assert property (!(acc && pwrite) |=> $stable(prio_levels))
        else $error("priority changed without a write");
    a_refused_write: assert property (acc && pwrite && !mapped |=> $stable(prio_levels))
        else $error("unmapped write changed a priority");
    a_error_flag: assert property (pslverr == (acc && !mapped))
        else $error("error flag wrong for the address");
    a_read_upper_zero: assert property (acc && !pwrite |->
        prdata[31:16] == 16'h0 && (mapped || prdata == 32'h0))
        else $error("unimplemented read bits not zero");
    a_read_checksum: assert property (acc && !pwrite && paddr == 8'h10 |->
        prdata[15:0] == {1'b0, prio_levels.checksum_error_priority, 1'b0,
        prio_levels.uart2_error_priority, 1'b0, prio_levels.uart1_error_priority, 4'h0})
        else $error("error priority register read wrong");
    a_read_low_volt: assert property (acc && !pwrite && paddr == 8'h14 |->
        prdata == {29'h0, prio_levels.low_voltage_priority})
        else $error("low voltage register read wrong");
    c_write_taken: cover property (acc && pwrite && mapped);
    c_refused: cover property (acc && pslverr);
    c_req_passed: cover property (req_active != 16'h0 && nz != 16'hFFFF);
endmodule

bind ipb_priority_bank ipb_priority_bank_properties u_props (
    .core_clk(core_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .prio_levels(prio_levels),
    .src_req(src_req),
    .req_active(req_active)
);

// File: ipb_priority_bank_tb.sv
// testbench: corner and random apb traffic against the priority bank
`timescale 1ns/1ps
module ipb_priority_bank_tb
    import ipb_pkg::*;
;
    localparam logic [15:0] MSK [8] = '{16'h0770, 16'h0770, 16'h0770, 16'h0770,
        16'h7770, 16'h0007, 16'h0070, 16'h7770};
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ipb_prio_bank_type prio_levels;
    logic [15:0] src_req = 16'h0;
    logic [15:0] req_active;
    logic [15:0] prev_req = 16'h0;
    logic [31:0] seed = 32'h74D8;
    logic [15:0] mdl [8];
    int error_cnt = 0;
    int compares = 0;

    ipb_priority_bank DUT (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .prio_levels(prio_levels), .src_req(src_req),
        .req_active(req_active));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // expected field view; struct msb holds source 0
    function automatic ipb_prio_bank_type exp_lv();
        return {mdl[0][10:8], mdl[0][6:4], mdl[1][10:8], mdl[1][6:4], mdl[2][10:8],
            mdl[2][6:4], mdl[3][10:8], mdl[3][6:4], mdl[4][14:12], mdl[4][10:8],
            mdl[4][6:4], mdl[5][2:0], mdl[6][6:4], mdl[7][14:12], mdl[7][10:8], mdl[7][6:4]};
    endfunction

    function automatic logic [15:0] exp_req(input ipb_prio_bank_type lv, input logic [15:0] r);
        logic [15:0] m;
        for (int i = 0; i < 16; i++) m[i] = r[i] && (lv[47-3*i -: 3] != 3'h0);
        return m;
    endfunction

    task automatic bad(input string what);
        error_cnt++;
        $display("mismatch at %0t: %s", $time, what);
    endtask

    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) bad($sformatf("read data %h expected %h", got, exp));
    endtask

    task automatic cmp_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) bad($sformatf("error flag %b expected %b", got, exp));
    endtask

    task automatic cmp_lv(input ipb_prio_bank_type got, input ipb_prio_bank_type exp);
        compares++;
        if (got !== exp) bad($sformatf("levels %h expected %h", got, exp));
    endtask

    task automatic cmp_req(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) bad($sformatf("requests %h expected %h", got, exp));
    endtask

    task automatic conclude();
        if (error_cnt == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16) bad("no ready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one edge after the write for the gated requests to settle
    task automatic chk_state();
        @(posedge core_clk);
        @(negedge core_clk);
        cmp_lv(prio_levels, exp_lv());
        cmp_req(req_active, exp_req(exp_lv(), prev_req));
    endtask

    task automatic wr(input int r, input logic [31:0] d, input logic [3:0] s);
        logic [15:0] lane;
        logic [31:0] q;
        logic e;
        lane = {{8{s[1]}}, {8{s[0]}}};
        apb(1'b1, 8'(4 * r), d, s, q, e);
        cmp_flag(e, 1'b0);
        mdl[r] = (mdl[r] & ~(lane & MSK[r])) | (d[15:0] & lane & MSK[r]);
        chk_state();
    endtask

    task automatic rd_chk(input int r);
        logic [31:0] q;
        logic e;
        apb(1'b0, 8'(4 * r), rnd(), 4'(rnd()), q, e);
        cmp_data(q, {16'h0, mdl[r]});
    endtask

    task automatic reset_chk();
        for (int r = 0; r < 8; r++) mdl[r] = MSK[r] & 16'h4444;
        chk_state();
        for (int r = 0; r < 8; r++) rd_chk(r);
    endtask

    initial
    begin
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        prev_req <= src_req;
        src_req <= 16'(rnd());
    end

    initial
    begin
        #400000;
        bad("watchdog expired");
        conclude();
    end

    initial
    begin
        logic [7:0] bad_addr [4];
        logic [31:0] q;
        logic e;
        bad_addr = '{8'h20, 8'h02, 8'hFC, 8'h13};
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        reset_chk();
        for (int r = 0; r < 8; r++)
        begin
            wr(r, 32'hFFFFFFFF, 4'hF);
            rd_chk(r);
        end
        // every code in every field, down to disabled
        for (int c = 7; c >= 0; c--)
        begin
            for (int r = 0; r < 8; r++)
                wr(r, {16'(rnd()), {4{1'b0, 3'(c)}}}, 4'hF);
            for (int r = 0; r < 8; r++) rd_chk(r);
        end
        repeat (200)
        begin
            if (rnd() & 32'h1)
                wr(int'(rnd() % 32'd8), rnd(), 4'(rnd()));
            else
                rd_chk(int'(rnd() % 32'd8));
        end
        foreach (bad_addr[i])
        begin
            apb(1'b1, bad_addr[i], 32'hFFFFFFFF, 4'hF, q, e);
            cmp_flag(e, 1'b1);
            apb(1'b0, bad_addr[i], 32'h0, 4'h0, q, e);
            cmp_data(q, 32'h0);
            chk_state();
        end
        // reset in mid-run restores level four
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        reset_chk();
        conclude();
    end
endmodule
